// File: src/cba_arbiter.sv
// ==========================================================
// Functional notes
// RULE1: a bus transaction once started runs to its end and is never pre-empted.
// RULE2: pending requests are granted instruction refill first, then buffered write, then data refill.
// RULE3: the write buffer holds up to four store words waiting to retire.
// RULE4: with no write running the read request rises one clock after an instruction miss; the code raises it two clocks after the miss.
// RULE5: an instruction miss during a running write stalls until that write ends.
// RULE6: a refill is a burst of four words, the last three on consecutive clocks.
// RULE7: a data miss spends one arbitration clock and drains the write buffer before reading.
// RULE8: buffered writes retire back to back while the core runs from its caches.
// RULE9: arbitration runs alongside execution so writes retire while the core fetches.
// RULE10: an output data register holds the word leaving the buffer, freeing its entry at once.
// RULE11: refill words are forwarded to the core as they are written into the cache.
// RULE12: memory returns the first word of a random read six clocks after arbitration.
// RULE13: memory finishes writes in six or three clocks as idle, page or non-page.
// RULE14: memory inserts three precharge clocks when a read follows a write.
// RULE15: reset empties the buffer, clears pending refills and leaves the bus idle.
module cba_arbiter
    import cba_pkg::*;
#(
    parameter int DATA_W = CBA_DATA_W,
    parameter int ADDR_W = CBA_ADDR_W
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic imiss_req,
    input wire logic [ADDR_W-1:0] imiss_addr,
    input wire logic dmiss_req,
    input wire logic [ADDR_W-1:0] dmiss_addr,
    input wire logic store_req,
    input wire logic [ADDR_W-1:0] store_addr,
    input wire logic [DATA_W-1:0] store_data,
    input wire logic mem_ack,
    input wire logic mem_rdata_valid,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic store_ready,
    output logic core_stall,
    output logic bus_read,
    output logic bus_write,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_wdata,
    output logic refill_valid,
    output logic refill_icache,
    output logic [DATA_W-1:0] refill_data,
    output logic refill_last
);
    // ==========================================================
    // state record
    typedef struct packed {
        cba_state_t st;
        cba_op_t op;
        logic [CBA_WB_PTR_W:0] count;
        logic [CBA_WB_PTR_W-1:0] wr_ptr;
        logic [CBA_WB_PTR_W-1:0] rd_ptr;
        logic hold_full;
        logic [ADDR_W-1:0] hold_addr;
        logic [DATA_W-1:0] hold_data;
        logic load_pend;
        logic ipend;
        logic dpend;
        logic [2:0] beat;
        logic bus_read;
        logic bus_write;
        logic [ADDR_W-1:0] bus_addr;
        logic [DATA_W-1:0] bus_wdata;
        logic refill_valid;
        logic refill_icache;
        logic [DATA_W-1:0] refill_data;
        logic refill_last;
        logic core_stall;
        logic store_ready;
    } cba_regs_t;

    cba_regs_t s_reg;
    cba_regs_t s_next;
    logic [ADDR_W+DATA_W-1:0] mem_rd;
    logic push;
    logic pop;

    function automatic logic [CBA_WB_PTR_W-1:0] ptr_inc(input logic [CBA_WB_PTR_W-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction

    // ==========================================================
    // buffer entries held in a small memory
    cba_wbuf_mem u_mem (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_ptr(s_reg.wr_ptr),
        .wr_data({store_addr, store_data}),
        .rd_ptr(s_reg.rd_ptr),
        .rd_data(mem_rd)
    );

    // store accepted while an entry is free [RULE3]
    assign push = store_req && (s_reg.count != 3'(CBA_WB_DEPTH));
    // move head into the output register when it is free [RULE10]
    assign pop = (s_reg.count != 3'h0) && !s_reg.hold_full && !s_reg.load_pend
                 && !(s_reg.count == 3'h1 && push);

    // ==========================================================
    // next-state logic
    always_comb
    begin
        s_next = s_reg;
        s_next.refill_valid = 1'b0;
        s_next.refill_last = 1'b0;
        // latch misses as pending refills
        if (imiss_req)
        begin
            s_next.ipend = 1'b1;
        end
        if (dmiss_req)
        begin
            s_next.dpend = 1'b1;
        end
        // buffer bookkeeping, head leaves into the data register [RULE10]
        if (push)
        begin
            s_next.wr_ptr = ptr_inc(s_reg.wr_ptr);
        end
        s_next.load_pend = pop;
        if (pop)
        begin
            s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
        end
        s_next.count = s_reg.count + {2'h0, push} - {2'h0, pop};
        if (s_reg.load_pend)
        begin
            s_next.hold_full = 1'b1;
            s_next.hold_addr = mem_rd[ADDR_W+DATA_W-1:DATA_W];
            s_next.hold_data = mem_rd[DATA_W-1:0];
        end
        unique case (s_reg.st)
            CBA_ST_IDLE:
            begin
                // one clock of arbitration after any miss [RULE4] [RULE7]
                if (s_reg.ipend || s_reg.dpend || imiss_req || dmiss_req)
                begin
                    s_next.st = CBA_ST_ARB;
                end
                else if (s_reg.hold_full)
                begin
                    // writes retire while core runs from caches [RULE8] [RULE9]
                    s_next.st = CBA_ST_WRITE;
                    s_next.bus_write = 1'b1;
                    s_next.bus_addr = s_reg.hold_addr;
                    s_next.bus_wdata = s_reg.hold_data;
                    s_next.op = CBA_OP_WRITE;
                end
            end
            CBA_ST_ARB:
            begin
                // priority: ifetch, buffered write, data refill [RULE2] [RULE7]
                if (s_reg.ipend)
                begin
                    s_next.st = CBA_ST_READ;
                    s_next.bus_read = 1'b1;
                    s_next.bus_addr = imiss_addr;
                    s_next.op = CBA_OP_IREAD;
                    // a miss raised with the grant stays pending
                    s_next.ipend = imiss_req;
                    s_next.beat = 3'h0;
                end
                else if (s_reg.hold_full)
                begin
                    s_next.st = CBA_ST_WRITE;
                    s_next.bus_write = 1'b1;
                    s_next.bus_addr = s_reg.hold_addr;
                    s_next.bus_wdata = s_reg.hold_data;
                    s_next.op = CBA_OP_WRITE;
                end
                else if (s_reg.dpend && s_reg.count == 3'h0 && !s_reg.load_pend)
                begin
                    s_next.st = CBA_ST_READ;
                    s_next.bus_read = 1'b1;
                    s_next.bus_addr = dmiss_addr;
                    s_next.op = CBA_OP_DREAD;
                    s_next.dpend = dmiss_req;
                    s_next.beat = 3'h0;
                end
                else if (!s_reg.dpend)
                begin
                    s_next.st = CBA_ST_IDLE;
                end
            end
            CBA_ST_WRITE:
            begin
                // write runs to its end, no pre-emption [RULE1] [RULE5]
                if (mem_ack)
                begin
                    s_next.bus_write = 1'b0;
                    s_next.hold_full = s_reg.load_pend;
                    s_next.op = CBA_OP_IDLE;
                    s_next.st = CBA_ST_ARB;
                end
            end
            CBA_ST_READ:
            begin
                // four-word burst forwarded as it arrives [RULE6] [RULE11]
                if (mem_rdata_valid)
                begin
                    s_next.bus_read = 1'b0;
                    s_next.refill_valid = 1'b1;
                    s_next.refill_icache = (s_reg.op == CBA_OP_IREAD);
                    s_next.refill_data = mem_rdata;
                    s_next.beat = s_reg.beat + 3'h1;
                    if (s_reg.beat == CBA_BURST_LAST)
                    begin
                        s_next.refill_last = 1'b1;
                        s_next.op = CBA_OP_IDLE;
                        s_next.st = CBA_ST_ARB;
                    end
                end
            end
            default:
            begin
                s_next.st = CBA_ST_IDLE;
            end
        endcase
        // stall on pending refill or full buffer with store waiting
        s_next.core_stall = s_next.ipend || s_next.dpend || s_next.st == CBA_ST_READ
                            || (store_req && !push);
        s_next.store_ready = (s_next.count != 3'(CBA_WB_DEPTH));
    end

    // ==========================================================
    // state register, reset empties buffer and idles bus [RULE15]
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs straight from the state record
    assign store_ready = s_reg.store_ready;
    assign core_stall = s_reg.core_stall;
    assign bus_read = s_reg.bus_read;
    assign bus_write = s_reg.bus_write;
    assign bus_addr = s_reg.bus_addr;
    assign bus_wdata = s_reg.bus_wdata;
    assign refill_valid = s_reg.refill_valid;
    assign refill_icache = s_reg.refill_icache;
    assign refill_data = s_reg.refill_data;
    assign refill_last = s_reg.refill_last;

    // ==========================================================
    // checks
    sequence write_open_s;
        s_reg.st == CBA_ST_WRITE && !mem_ack;
    endsequence

    no_preempt_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
        write_open_s |=> s_reg.st == CBA_ST_WRITE)
        else $error("write pre-empted");
    iread_first_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
        (s_reg.st == CBA_ST_ARB && s_reg.ipend) |=> s_reg.op == CBA_OP_IREAD)
        else $error("ifetch not granted first");
    depth_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
        s_reg.count <= 3'(CBA_WB_DEPTH))
        else $error("buffer overfilled");
    arb_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
        (s_reg.st == CBA_ST_IDLE && imiss_req) |=> s_reg.st == CBA_ST_ARB ##1 bus_read)
        else $error("read request not one clock after arbitration");
    dread_drained_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE7]
        $rose(bus_read) && s_reg.op == CBA_OP_DREAD |-> $past(s_reg.count) == 3'h0)
        else $error("data refill before buffer drained");
    burst_end_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE6]
        refill_last |-> refill_valid && $past(s_reg.beat) == CBA_BURST_LAST)
        else $error("burst length wrong");
    reset_idle_a: assert property (@(posedge core_clk) // [RULE15]
        !rst_b |=> !bus_read && !bus_write && s_reg.count == 3'h0)
        else $error("not idle after reset");
    store_wait_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
        (store_req && s_reg.count == 3'(CBA_WB_DEPTH)) |=> core_stall)
        else $error("store to full buffer not stalled");
endmodule

// File: src/cba_pkg.sv
package cba_pkg;
    // ==========================================================
    // widths and depths
    localparam int CBA_DATA_W = 32;
    localparam int CBA_ADDR_W = 32;
    localparam int CBA_WB_DEPTH = 4;
    localparam int CBA_WB_PTR_W = 2;
    localparam int CBA_BURST_LEN = 4;
    localparam logic [2:0] CBA_BURST_LAST = 3'h3;
    // ==========================================================
    // timing figures and derived cycle counts
    localparam int CBA_CLK_MHZ = 25;
    localparam int CBA_ARB_CYCLES = 1;
    // ==========================================================
    // bus operation codes
    typedef enum logic [1:0] {
        CBA_OP_IDLE,
        CBA_OP_IREAD,
        CBA_OP_WRITE,
        CBA_OP_DREAD
    } cba_op_t;
    // ==========================================================
    // arbiter states
    typedef enum logic [2:0] {
        CBA_ST_IDLE,
        CBA_ST_ARB,
        CBA_ST_WRITE,
        CBA_ST_READ
    } cba_state_t;
endpackage

// File: src/cba_wbuf_mem.sv
module cba_wbuf_mem
    import cba_pkg::*;
#(
    parameter int DATA_W = CBA_DATA_W + CBA_ADDR_W,
    parameter int DEPTH = CBA_WB_DEPTH,
    parameter int PTR_W = CBA_WB_PTR_W
)(
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [PTR_W-1:0] wr_ptr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [PTR_W-1:0] rd_ptr,
    output logic [DATA_W-1:0] rd_data
);
    // ==========================================================
    // storage with registered read port
    logic [DATA_W-1:0] mem_reg [DEPTH];

    // write port and read register
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem_reg[wr_ptr] <= wr_data;
        end
        rd_data <= mem_reg[rd_ptr];
    end
endmodule

// File: testbench/cba_mem_model.sv
module cba_mem_model
    import cba_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [3:0] extra,
    output logic mem_ack,
    output logic mem_rdata_valid,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy, rd, gap, wrote, open;
    logic [31:0] base;
    logic [20:0] row;
    int cnt, wd;
    // ==========
    // one access at a time: latency count, then an ack or four words
    always @(posedge core_clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata_valid <= 1'b0;
        gap <= 1'b0;
        // released data line keeps changing outside valid words
        mem_rdata <= !rst_b ? 32'h0 : (busy && rd && cnt <= 1) ? base + 32'(wd) : ~mem_rdata;
        if (!rst_b)
        begin
            busy <= 1'b0;
            wrote <= 1'b0;
            open <= 1'b0;
        end
        else if (!busy && !gap && (bus_read || bus_write))
        begin
            busy <= 1'b1;
            rd <= bus_read;
            base <= bus_addr;
            wd <= 0;
            // read 6, plus 3 of precharge after a write; page write 3, others 6
            cnt <= (bus_read ? (wrote ? 9 : 6) : (open && row == bus_addr[31:11] ? 3 : 6))
                + int'(extra);
            row <= bus_addr[31:11];
            open <= 1'b1;
            wrote <= bus_write;
        end
        else if (busy && cnt > 1)
            cnt <= cnt - 1;
        else if (busy && !rd)
        begin
            mem_ack <= 1'b1;
            busy <= 1'b0;
            gap <= 1'b1;
        end
        else if (busy)
        begin
            mem_rdata_valid <= 1'b1;
            wd <= wd + 1;
            busy <= (wd != 3);
            gap <= 1'b1;
        end
    end
endmodule

// File: testbench/tb_cba_arbiter.sv
module tb_cba_arbiter
    import cba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_b = 1'b0, imiss_req = 1'b0, dmiss_req = 1'b0, store_req = 1'b0;
    logic [31:0] imiss_addr = 32'h0, dmiss_addr = 32'h0, store_addr = 32'h0, store_data = 32'h0;
    logic [3:0] extra = 4'h0;
    logic mem_ack, mem_rdata_valid, store_ready, core_stall, bus_read, bus_write;
    logic refill_valid, refill_icache, refill_last, prev_rd = 1'b0, prev_wr = 1'b0, prev_ack;
    logic [31:0] mem_rdata, bus_addr, bus_wdata, refill_data, rd_base, hold_addr;
    logic [31:0] log_q[$], exp_q[$];
    int n_mismatch = 0, checked = 0, seed = 86, nref = 0, n_wait = 0;

    always #20 core_clk = ~core_clk;

    cba_arbiter cba_arbiter_i (
        .core_clk, .rst_b, .imiss_req, .imiss_addr, .dmiss_req, .dmiss_addr, .store_req,
        .store_addr, .store_data, .mem_ack, .mem_rdata_valid, .mem_rdata, .store_ready,
        .core_stall, .bus_read, .bus_write, .bus_addr, .bus_wdata, .refill_valid,
        .refill_icache, .refill_data, .refill_last
    );
    cba_mem_model cba_mem_model_i (
        .core_clk, .rst_b, .bus_read, .bus_write, .bus_addr, .extra, .mem_ack,
        .mem_rdata_valid, .mem_rdata
    );

    // ==========
    // checking and closing
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] rnd_addr(input logic [31:0] region);
        rnd_addr = region | (32'($random(seed)) & 32'h0000_0ffc);
    endfunction

    // offer one store and wait until it is taken
    task automatic store(input logic [31:0] a);
        int i;
        store_addr <= a;
        store_data <= ~a;
        store_req <= 1'b1;
        exp_q.push_back(a);
        @(negedge core_clk);
        for (i = 0; i < 200 && store_ready !== 1'b1; i++)
        begin
            if (i > 0)
                chk("stall_full", core_stall, 1);
            n_wait++;
            @(negedge core_clk);
        end
        chk("store_timeout", 32'(i == 200), 0);
        if (i == 200)
            end_sim();
        @(posedge core_clk);
    endtask

    // wait for a quiet bus, then compare the transfer order
    task automatic settle(input string what);
        int q, i;
        q = 0;
        for (i = 0; i < 600 && q < 12; i++)
        begin
            @(negedge core_clk);
            q = (bus_read || bus_write || refill_valid || core_stall) ? 0 : q + 1;
        end
        chk("timeout", 32'(q < 12), 0);
        if (q < 12)
            end_sim();
        chk({what, "_count"}, log_q.size(), exp_q.size());
        while (exp_q.size() > 0 && log_q.size() > 0)
            chk(what, log_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        log_q.delete();
        $display("test %s done", what);
    endtask

    // ==========
    // bus watcher: logs transfer starts, checks write data and refill words
    always @(posedge core_clk)
    begin
        if (rst_b)
        begin
            if (bus_read && bus_write)
                chk("bus_overlap", 1, 0);
            if ((bus_read && prev_rd || bus_write && prev_wr && !prev_ack) && bus_addr !== hold_addr)
                chk("bus_addr_hold", bus_addr, hold_addr);
            if (bus_write && (!prev_wr || prev_ack))
            begin
                log_q.push_back(bus_addr);
                chk("bus_wdata", bus_wdata, ~bus_addr);
            end
            if (bus_read && !prev_rd)
            begin
                log_q.push_back(bus_addr);
                rd_base = bus_addr;
                nref = 0;
            end
            if (refill_valid)
            begin
                chk("refill_data", refill_data, rd_base + 32'(nref));
                chk("refill_last", refill_last, 32'(nref == 3));
                chk("refill_icache", refill_icache, 32'(rd_base == imiss_addr));
                nref++;
                if (refill_last && refill_icache)
                    imiss_req <= 1'b0;
                if (refill_last && !refill_icache)
                    dmiss_req <= 1'b0;
            end
        end
        prev_rd = bus_read;
        prev_wr = bus_write;
        prev_ack = mem_ack;
        hold_addr = bus_addr;
    end

    // ==========
    // main sequence
    initial
    begin
        int i, n;
        logic [31:0] a;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("reset_bus", {bus_read, bus_write, refill_valid, core_stall}, 0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        chk("ready_after_reset", store_ready, 1);
        // fetch miss on an idle bus
        @(posedge core_clk);
        imiss_addr <= 32'h0000_1000;
        imiss_req <= 1'b1;
        exp_q.push_back(32'h0000_1000);
        @(posedge core_clk);
        imiss_req <= 1'b0;
        @(negedge core_clk);
        chk("read_early", bus_read, 0);
        @(negedge core_clk);
        chk("read_on_time", bus_read, 1);
        settle("fetch_idle");
        // stores past a full buffer, slow memory
        @(posedge core_clk);
        extra <= 4'h4;
        repeat (8) store(rnd_addr(32'h0010_0000));
        store_req <= 1'b0;
        chk("full_refused", 32'(n_wait > 0), 1);
        settle("write_order");
        // fetch and data miss raised while a write runs
        @(posedge core_clk);
        extra <= 4'h0;
        repeat (3) store(rnd_addr(32'h0020_0000));
        store_req <= 1'b0;
        for (i = 0; i < 100 && bus_write !== 1'b1; i++)
            @(negedge core_clk);
        chk("write_start", bus_write, 1);
        @(posedge core_clk);
        imiss_addr <= 32'h0000_3000;
        dmiss_addr <= 32'h0000_4000;
        imiss_req <= 1'b1;
        dmiss_req <= 1'b1;
        exp_q.insert(1, 32'h0000_3000);
        exp_q.push_back(32'h0000_4000);
        @(posedge core_clk);
        imiss_req <= 1'b0;
        dmiss_req <= 1'b0;
        settle("priority_order");
        // data misses behind random numbers of buffered stores
        repeat (4)
        begin
            @(posedge core_clk);
            extra <= 4'($random(seed)) & 4'h3;
            n = int'(32'($random(seed)) & 32'h7) % 5;
            repeat (n) store(rnd_addr(32'h0030_0000));
            store_req <= 1'b0;
            a = rnd_addr(32'h0000_8000);
            dmiss_addr <= a;
            dmiss_req <= 1'b1;
            exp_q.push_back(a);
            @(posedge core_clk);
            dmiss_req <= 1'b0;
            settle("drain_first");
        end
        // reset in mid-run drops buffered stores and a pending data miss
        @(posedge core_clk);
        extra <= 4'h4;
        repeat (2) store(rnd_addr(32'h0040_0000));
        store_req <= 1'b0;
        dmiss_addr <= 32'h0000_9000;
        dmiss_req <= 1'b1;
        @(posedge core_clk);
        dmiss_req <= 1'b0;
        rst_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk("reset_mid", {bus_read, bus_write, core_stall, store_ready}, 0);
        @(negedge core_clk);
        chk("reset_mid_ready", {bus_read, bus_write, core_stall, store_ready}, 1);
        exp_q.delete();
        log_q.delete();
        settle("reset_mid");
        end_sim();
    end
endmodule
